// ===== include/bfie_pkg.sv
// Package for the boost fault interrupt enable register block.
// Assumes a single core clock domain and a plain register port.
package bfie_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // Register offsets (word index on the plain port)
   localparam logic [3:0] OFS_IRQ_EN = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_MASK = 4'h2;
   localparam logic [3:0] OFS_RESERVED_W = 4'h3;
   // Number of fault sources and field positions (low bit of each field)
   localparam int NSRC = 4;
   localparam int POS_OVH = 2;
   localparam int POS_OCP = 4;
   localparam int POS_FREQ = 6;
   localparam int POS_MODE = 8;
   // Field codes
   localparam logic [1:0] RD_DISABLED = 2'h0;
   localparam logic [1:0] RD_ENABLED = 2'h2;
   localparam logic [1:0] WR_DISABLE = 2'h1;
   localparam logic [1:0] WR_ENABLE = 2'h3;
   // Reset enable per source: index 0 over-voltage, 1 over-current, 2 freq resistor, 3 mode resistor
   localparam logic [3:0] EN_RESET = 4'h3;
   localparam logic [3:0] MASK_RESET = 4'hF;
   localparam logic [1:0] RSVD_RESET = 2'h0;
endpackage

// ===== design/bfie_field.sv
// One two-bit enable field with write-one-to-disable, write-three-to-enable codes.
// Assumes the write strobe is a one-cycle pulse on clk_i.
`timescale 1ns/1ps
`default_nettype none
module bfie_field
#(
   parameter logic RESET_EN = 1'b0
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic wr_i,
   input wire logic [1:0] code_i,
   output logic en_o,
   output logic [1:0] rd_o
);
   import bfie_pkg::*;
   logic en_reg;
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         en_reg <= RESET_EN;
      end
      else if (wr_i)
      begin
         if (code_i == WR_DISABLE)
         begin
            en_reg <= 1'b0;
         end
         else if (code_i == WR_ENABLE)
         begin
            en_reg <= 1'b1;
         end
         // Other codes keep the state
      end
   end
   assign en_o = en_reg;
   assign rd_o = en_reg ? RD_ENABLED : RD_DISABLED;
endmodule
`default_nettype wire

// ===== design/bfie_top.sv
// Boost fault interrupt enable register with sticky status, mask and irq output.
// Assumes fault events arrive as pulses on clk_i; register port answers one cycle later.
//
// Function
// - Field reads 0h disabled, 2h enabled
// - Writing 1h disables the interrupt
// - Writing 3h enables the interrupt
// - Bits 5-4 over-current, reset enabled
// - Bits 3-2 over-voltage-high, reset enabled
// - Bits 1-0 reserved, reset 0h
// - Bits 9-8 mode resistor missing, reset disabled
// - Bits 7-6 freq resistor missing, reset disabled
`timescale 1ns/1ps
`default_nettype none
module bfie_top
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [bfie_pkg::ADDR_W-1:0] addr_i,
   input wire logic [bfie_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [bfie_pkg::NSRC-1:0] fault_evt_i,
   output logic [bfie_pkg::DATA_W-1:0] rdata_o,
   output logic [bfie_pkg::NSRC-1:0] fault_irq_en_o,
   output logic irq_o
);
   import bfie_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode, field, status and read port signals
   // Low bit of each enable field, indexed by source
   localparam int POS [NSRC] = '{POS_OVH, POS_OCP, POS_FREQ, POS_MODE};

   // Register port decode
   logic wr_en_sel;
   logic wr_status_sel;
   logic wr_mask_sel;

   // Enable fields
   wire logic [NSRC-1:0] en;
   wire logic [1:0] fld_rd [NSRC];
   logic [DATA_W-1:0] en_rd;
   logic [1:0] rsvd_reg;
   logic [1:0] rsvd_next;

   // Status, mask and interrupt
   wire logic [NSRC-1:0] status_next;
   wire logic [NSRC-1:0] pend;
   logic [NSRC-1:0] status_reg;
   logic [NSRC-1:0] mask_reg;
   logic [NSRC-1:0] mask_next;
   logic irq_reg;
   logic irq_next;
   logic [NSRC-1:0] fault_irq_en_reg;

   // Read port
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   ////////////////////////////////////////////////////////////////////////////////
   // Register port decode
   assign wr_en_sel = wr_i && (addr_i == OFS_IRQ_EN);
   assign wr_status_sel = wr_i && (addr_i == OFS_STATUS);
   assign wr_mask_sel = wr_i && (addr_i == OFS_MASK);

   ////////////////////////////////////////////////////////////////////////////////
   // Per-source enable field and status update
   genvar g;
   generate
      for (g = 0; g < NSRC; g++)
      begin : gen_src
         // Per-source working signals
         logic set_hit;
         logic clr_hit;

         // Each field takes the two write bits at its own position
         bfie_field #(.RESET_EN(EN_RESET[g])) u_field
         (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .wr_i(wr_en_sel),
            .code_i(wdata_i[POS[g]+1:POS[g]]),
            .en_o(en[g]),
            .rd_o(fld_rd[g])
         );

         // An event counts only while its own field is enabled
         assign set_hit = fault_evt_i[g] & en[g];
         assign clr_hit = wr_status_sel & wdata_i[g];
         // A new event wins over a clear in the same cycle
         assign status_next[g] = set_hit | (status_reg[g] & ~clr_hit);
         assign pend[g] = status_reg[g] & mask_reg[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Enable register read image; bits above the top field read zero
   always_comb
   begin
      en_rd = '0;
      en_rd[1:0] = rsvd_reg;
      for (int i = 0; i < NSRC; i++)
      begin
         en_rd[POS[i]+:2] = fld_rd[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reserved bits store a value but steer nothing
   assign rsvd_next = wr_en_sel ? wdata_i[1:0] : rsvd_reg;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rsvd_reg <= RSVD_RESET;
      end
      else
      begin
         rsvd_reg <= rsvd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear
   // Set and clear are resolved per source above
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         status_reg <= '0;
      end
      else
      begin
         status_reg <= status_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mask, a set bit lets its status reach the interrupt
   assign mask_next = wr_mask_sel ? wdata_i[NSRC-1:0] : mask_reg;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         mask_reg <= MASK_RESET;
      end
      else
      begin
         mask_reg <= mask_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt level and enable image
   assign irq_next = |pend;

   // Level follows the pending bits one cycle later
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= irq_next;
      end
   end

   // Enable image lags the fields by one cycle
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fault_irq_en_reg <= '0;
      end
      else
      begin
         fault_irq_en_reg <= en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read port
   always_comb
   begin
      rd_mux = '0;
      case (addr_i)
         OFS_IRQ_EN: rd_mux = en_rd;
         OFS_STATUS: rd_mux[NSRC-1:0] = status_reg;
         OFS_MASK: rd_mux[NSRC-1:0] = mask_reg;
         OFS_RESERVED_W: rd_mux = '0;
         default: rd_mux = '0;
      endcase
   end

   // Read data stand for one cycle, zero otherwise
   assign rdata_next = rd_i ? rd_mux : '0;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs come straight from their flip-flops
   assign rdata_o = rdata_reg;
   assign fault_irq_en_o = fault_irq_en_reg;
   assign irq_o = irq_reg;
endmodule
`default_nettype wire

// ===== verification/bfie_chk.sv
// Assertions on the enable register block ports.
// Assumes a bind onto bfie_top with one clock.
`timescale 1ns/1ps
`default_nettype none
module bfie_chk
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [3:0] fault_evt_i,
   input wire logic [15:0] rdata_o,
   input wire logic [3:0] fault_irq_en_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_w; wr_i && addr_i == 4'h0; endsequence
   sequence s_r; rd_i && addr_i == 4'h0; endsequence
   ////////////////////////////////////////
   property p_rd; s_r |=> rdata_o[9:2] == {fault_irq_en_o[3], 1'b0, fault_irq_en_o[2],
      1'b0, fault_irq_en_o[1], 1'b0, fault_irq_en_o[0], 1'b0}; endproperty
   a_rd: assert property (p_rd) else $error("enable readback");
   property p_ocd; s_w ##0 wdata_i[5:4] == 2'h1 |=> ##1 !fault_irq_en_o[1]; endproperty
   a_ocd: assert property (p_ocd) else $error("disable code");
   property p_mdd; s_w ##0 wdata_i[9:8] == 2'h1 |=> ##1 !fault_irq_en_o[3]; endproperty
   a_mdd: assert property (p_mdd) else $error("disable code");
   property p_ove; s_w ##0 wdata_i[3:2] == 2'h3 |=> ##1 fault_irq_en_o[0]; endproperty
   a_ove: assert property (p_ove) else $error("enable code");
   property p_fqe; s_w ##0 wdata_i[7:6] == 2'h3 |=> ##1 fault_irq_en_o[2]; endproperty
   a_fqe: assert property (p_fqe) else $error("enable code");
   property p_hold; s_w ##0 wdata_i[6] == 1'b0 |=> ##1 $stable(fault_irq_en_o[2]); endproperty
   a_hold: assert property (p_hold) else $error("hold code");
   property p_rsv; s_w ##0 wdata_i[9:2] == 8'h0 |=> ##1 $stable(fault_irq_en_o); endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits");
   property p_idle; !rd_i |=> rdata_o == 16'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data idle");
endmodule
bind bfie_top bfie_chk u_chk (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .fault_evt_i, .rdata_o, .fault_irq_en_o, .irq_o);
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the enable register block.
// Assumes bfie_top and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bfie_pkg::*;
   logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, irq_o;
   logic [3:0] addr_i = 0, fault_evt_i = 0, fault_irq_en_o;
   logic [15:0] wdata_i = 0, rdata_o, d, m = 16'h0028;
   logic [15:0] tbl [4] = '{16'h0003, 16'h03FC, 16'h02A8, 16'h0154};
   logic [31:0] lf = 32'h712AA21E;
   int num_errors = 0, check_count = 0;
   bfie_top u_bfie_top (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .fault_evt_i, .rdata_o, .fault_irq_en_o, .irq_o);
   initial forever #5 clk_i = ~clk_i;
   ////////////////////////////////////////
   function automatic logic [31:0] nx(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected register after a write; low bits are plain storage
   function automatic logic [15:0] upd(logic [15:0] o, logic [15:0] v);
      for (int i = 2; i < 10; i += 2)
         if (v[i]) o[i+1] = v[i+1];
      return {6'h0, o[9:2], v[1:0]};
   endfunction
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, r, input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wdata_i <= v;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] e);
      bus(1'b0, 1'b1, a, '0);
      bus(1'b0, 1'b0, a, '0);
      #1 cmp(rdata_o, e);
      cmp({12'h0, fault_irq_en_o}, {12'h0, m[9], m[7], m[5], m[3]});
   endtask
   task automatic end_of_test;
      $display("Errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      #300000 num_errors++;
      end_of_test();
   end
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rdc(OFS_IRQ_EN, m);
      bus(1'b0, 1'b0, OFS_IRQ_EN, '0);
      fault_evt_i <= 4'hC;
      bus(1'b0, 1'b0, OFS_IRQ_EN, '0);
      fault_evt_i <= 4'h0;
      rdc(OFS_STATUS, 16'h0);
      bus(1'b1, 1'b0, 4'h9, 16'hFFFF);
      rdc(4'h9, 16'h0);
      for (int i = 0; i < 60; i++)
      begin
         d = (i < 4) ? tbl[i] : lf[15:0];
         lf = nx(lf);
         bus(1'b1, 1'b0, OFS_IRQ_EN, d);
         m = upd(m, d);
         rdc(OFS_IRQ_EN, m);
      end
      bus(1'b1, 1'b0, OFS_IRQ_EN, 16'h03FC);
      m = 16'h02A8;
      // The event follows the enabling write by one cycle
      bus(1'b0, 1'b0, OFS_IRQ_EN, '0);
      fault_evt_i <= 4'h2;
      bus(1'b0, 1'b0, OFS_IRQ_EN, '0);
      fault_evt_i <= 4'h0;
      rdc(OFS_STATUS, 16'h0002);
      cmp({15'h0, irq_o}, 16'h1);
      bus(1'b1, 1'b0, OFS_MASK, 16'h0);
      rdc(OFS_MASK, 16'h0);
      cmp({15'h0, irq_o}, 16'h0);
      bus(1'b1, 1'b0, OFS_MASK, 16'hF);
      bus(1'b1, 1'b0, OFS_STATUS, 16'h2);
      rdc(OFS_STATUS, 16'h0);
      cmp({15'h0, irq_o}, 16'h0);
      // Clear and event in one cycle: the event must win
      repeat (2)
      begin
         bus(1'b1, 1'b0, OFS_STATUS, 16'h2);
         fault_evt_i <= 4'h2;
      end
      bus(1'b0, 1'b0, OFS_IRQ_EN, '0);
      fault_evt_i <= 4'h0;
      rdc(OFS_STATUS, 16'h0002);
      cmp({15'h0, irq_o}, 16'h1);
      end_of_test();
   end
endmodule
`default_nettype wire
